// [rtl/vic_register_map.sv]
/*
 * Register map, vectoring, nesting and core line drive of a 32-source
 * vectored interrupt controller, reached as a classic Wishbone slave.
 * Assumes sources and bus signals synchronous to mclk and a bus master that
 * keeps one request standing until it sees ack.
 */
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns

// What this block does
// - Decode registers in 4-Kbyte window at base
// - Mode register priority bits 2:0, 7 highest
// - Fast source 0 ignores its priority
// - Internal sources: bit 5 picks level or edge
// - External sources: low, falling, high, rising
// - Thirty-two handler address registers from 0x80
// - Current vector returns highest pending source handler
// - No enabled pending source above current priority returns spurious vector
// - Spurious vector register read-write, resets zero
// - After reset external pending follows input level
// - Enable, disable, clear, set write-only commands
// - End-of-service write concludes current interrupt
// - Redirect enable, disable commands and status
// - Fast vector register read-only, resets zero
// - Core line status shows both request lines
// - Fast vector gives source 0 handler or spurious
// - Pending bit reads one while source pending
// - Status register returns current source number
module vic_register_map
    import vic_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [31:0] wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatW,
    output logic      [31:0] wbDatR,
    output logic             wbAck,
    input  wire logic [31:0] sourceIn,
    output logic             normalRequestLineN,
    output logic             fastRequestLineN
);

    vic_state_t s_q;
    vic_state_t s_d;

    logic [31:0] lvl;
    logic [31:0] pend;
    logic [31:0] cand;
    logic [31:0] edgeSet;
    logic [31:0] setCmd;
    logic [31:0] clrCmd;
    logic [31:0] wMask;
    logic [11:0] off;
    logic        bestValid;
    logic [4:0]  bestId;
    logic [2:0]  bestPrio;
    logic        preempt;
    logic        fastReq;
    logic        req;
    logic        hit;
    logic        rdStb;
    logic        wrStb;
    logic        doAccept;
    logic [4:0]  accId;
    logic [31:0] curVector;
    logic [31:0] fastVector;

    // Turns a raw source into its active-high level under the programmed type.
    function automatic logic srcLevel(input logic ext, input logic [1:0] tt, input logic x);
        srcLevel = (ext && !tt[1]) ? !x : x;
    endfunction : srcLevel

    // Expands Wishbone byte selects into a bit mask.
    function automatic logic [31:0] laneMask(input logic [3:0] sel);
        laneMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : laneMask

    // Merges a write into a stored word through the lane mask.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction : merge

    // Next-state logic: sources, arbitration, bus decode and side effects.
    always_comb
    begin
        s_d        = s_q;
        lvl        = RESET_WORD;
        pend       = RESET_WORD;
        edgeSet    = RESET_WORD;
        setCmd     = RESET_WORD;
        clrCmd     = RESET_WORD;
        bestValid  = 1'b0;
        bestId     = 5'h00;
        bestPrio   = 3'h0;
        doAccept   = 1'b0;
        accId      = 5'h00;
        wMask      = laneMask(wbSel);
        off        = {wbAdr[11:2], 2'b00};

        // Level and edge detection per source.
        for (int i = 0; i < NUM_SOURCES; i++)
        begin
            lvl[i]     = srcLevel(EXT_SOURCE_MASK[i], s_q.trig[i], sourceIn[i]);
            edgeSet[i] = s_q.trig[i][0] && lvl[i] && !s_q.lvlPrev[i];
            // Level sources also see the input directly, so external levels
            // show as pending straight after reset without any latch.
            pend[i]    = s_q.trig[i][0] ? s_q.latch[i] : (lvl[i] | s_q.latch[i]);
        end
        s_d.lvlPrev = lvl;

        // Normal candidates exclude source 0 and redirected sources, so source
        // 0 never enters the priority compare.
        cand    = pend & s_q.enab & ~s_q.ffsr;
        cand[0] = 1'b0;

        // Highest priority wins; on a tie the lowest source number wins.
        for (int i = 1; i < NUM_SOURCES; i++)
        begin
            if (cand[i] && (!bestValid || s_q.prio[i] > bestPrio))
            begin
                bestValid = 1'b1;
                bestId    = 5'(i);
                bestPrio  = s_q.prio[i];
            end
        end
        preempt = bestValid && (!s_q.curValid || bestPrio > s_q.curPrio);
        fastReq = (pend[0] && s_q.enab[0]) || (|(pend & s_q.enab & s_q.ffsr & 32'hFFFF_FFFE));

        // The general mask holds both core lines inactive.
        s_d.irqAct = preempt && !s_q.dbg[DBG_GMASK];
        s_d.fiqAct = fastReq && !s_q.dbg[DBG_GMASK];

        curVector  = preempt ? s_q.vec[bestId] : s_q.spu;
        fastVector = fastReq ? s_q.vec[0] : s_q.spu;

        // One ack per request; side effects act only on the acking edge.
        req        = wbCyc && wbStb && !s_q.ack;
        hit        = wbAdr[31:VIC_SPACE_BITS] == VIC_BASE_ADDR[31:VIC_SPACE_BITS];
        rdStb      = req && hit && !wbWe;
        wrStb      = req && hit && wbWe;
        s_d.ack    = req;
        s_d.rdat   = RESET_WORD;

        // Read path.
        if (rdStb)
        begin
            if (off < OFF_HANDLER_ADDR)
            begin
                s_d.rdat[PRIO_MSB:PRIO_LSB] = s_q.prio[off[6:2]];
                s_d.rdat[TRIG_MSB:TRIG_LSB] = s_q.trig[off[6:2]];
            end
            else if (off <= OFF_HANDLER_END)
            begin
                s_d.rdat = s_q.vec[off[6:2]];
            end
            else
            begin
                unique case (off)
                    OFF_CUR_VECTOR:
                    begin
                        s_d.rdat = curVector;
                        if (!s_q.dbg[DBG_PROTECT])
                        begin
                            doAccept = preempt;
                            accId    = bestId;
                        end
                        else
                        begin
                            // Protect mode only remembers the pick.
                            s_d.memId    = bestId;
                            s_d.memValid = preempt;
                        end
                    end
                    OFF_FAST_VECTOR:
                    begin
                        s_d.rdat = fastVector;
                        // Redirected sources stay set; only source 0's edge is taken.
                        if (pend[0] && s_q.enab[0] && s_q.trig[0][0])
                        begin
                            clrCmd[0] = 1'b1;
                        end
                    end
                    OFF_CUR_STATUS:   s_d.rdat[4:0] = s_q.curId;
                    OFF_PENDING:      s_d.rdat = pend;
                    OFF_ENABLED:      s_d.rdat = s_q.enab;
                    OFF_CORE_LINES:
                    begin
                        s_d.rdat[CORE_FAST_BIT] = s_q.fiqAct;
                        s_d.rdat[CORE_NORM_BIT] = s_q.irqAct;
                    end
                    OFF_SPURIOUS:     s_d.rdat = s_q.spu;
                    OFF_DEBUG_CTRL:   s_d.rdat[1:0] = s_q.dbg;
                    OFF_REDIR_STATUS: s_d.rdat = s_q.ffsr;
                    default:          s_d.rdat = RESET_WORD;
                endcase
            end
        end

        // Write path.
        if (wrStb)
        begin
            if (off < OFF_HANDLER_ADDR)
            begin
                if (wbSel[0])
                begin
                    s_d.prio[off[6:2]] = wbDatW[PRIO_MSB:PRIO_LSB];
                    s_d.trig[off[6:2]] = wbDatW[TRIG_MSB:TRIG_LSB];
                end
            end
            else if (off <= OFF_HANDLER_END)
            begin
                s_d.vec[off[6:2]] = merge(s_q.vec[off[6:2]], wbDatW, wMask);
            end
            else
            begin
                unique case (off)
                    OFF_CUR_VECTOR:
                    begin
                        // In protect mode the write completes the earlier read.
                        if (s_q.dbg[DBG_PROTECT] && s_q.memValid)
                        begin
                            doAccept     = 1'b1;
                            accId        = s_q.memId;
                            s_d.memValid = 1'b0;
                        end
                    end
                    OFF_ENABLE_CMD:    s_d.enab = s_q.enab | (wbDatW & wMask);
                    OFF_DISABLE_CMD:   s_d.enab = s_q.enab & ~(wbDatW & wMask);
                    OFF_CLEAR_CMD:     clrCmd = wbDatW & wMask;
                    OFF_SET_CMD:       setCmd = wbDatW & wMask;
                    OFF_END_SERVICE:
                    begin
                        // Pop the interrupted context, or go idle when none is stacked.
                        if (s_q.depth != 4'h0)
                        begin
                            s_d.depth   = 4'(s_q.depth - 4'h1);
                            s_d.curId   = s_q.stkId[3'(s_q.depth - 4'h1)];
                            s_d.curPrio = s_q.stkPrio[3'(s_q.depth - 4'h1)];
                        end
                        else
                        begin
                            s_d.curValid = 1'b0;
                            s_d.curId    = 5'h00;
                        end
                    end
                    OFF_SPURIOUS:      s_d.spu = merge(s_q.spu, wbDatW, wMask);
                    OFF_DEBUG_CTRL:
                    begin
                        if (wbSel[0])
                        begin
                            s_d.dbg = wbDatW[1:0];
                        end
                    end
                    OFF_REDIR_ENABLE:  s_d.ffsr = s_q.ffsr | (wbDatW & wMask);
                    OFF_REDIR_DISABLE: s_d.ffsr = s_q.ffsr & ~(wbDatW & wMask);
                    default:           s_d.ffsr = s_q.ffsr;
                endcase
            end
        end

        // Acknowledge: stack the old context and make the pick current.
        if (doAccept)
        begin
            if (s_q.curValid)
            begin
                s_d.stkId[s_q.depth[2:0]]   = s_q.curId;
                s_d.stkPrio[s_q.depth[2:0]] = s_q.curPrio;
                s_d.depth                   = 4'(s_q.depth + 4'h1);
            end
            s_d.curId    = accId;
            s_d.curPrio  = s_q.prio[accId];
            s_d.curValid = 1'b1;
            // Level sources must be cleared at the peripheral instead.
            if (s_q.trig[accId][0])
            begin
                clrCmd[accId] = 1'b1;
            end
        end

        // A new edge or set command in the clearing cycle is kept.
        s_d.latch = (s_q.latch & ~clrCmd) | edgeSet | setCmd;
    end

    // State register.
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Bus and core line outputs, all straight from flip-flops.
    assign wbDatR             = s_q.rdat;
    assign wbAck              = s_q.ack;
    assign normalRequestLineN = !s_q.irqAct;
    assign fastRequestLineN   = !s_q.fiqAct;

endmodule : vic_register_map

// [rtl/vic_pkg.sv]
/*
 * Constants and the state type of the vectored interrupt controller register map.
 * Assumes a 32-bit classic Wishbone bus, 32 interrupt sources and one clock.
 */
package vic_pkg;

    // Placement of the 4-Kbyte register window in the system address space.
    localparam logic [31:0] VIC_BASE_ADDR     = 32'hFFFF_F000;
    localparam int          VIC_SPACE_BITS    = 12;

    // Byte offsets inside the window.
    localparam logic [11:0] OFF_SOURCE_MODE   = 12'h000;
    localparam logic [11:0] OFF_HANDLER_ADDR  = 12'h080;
    localparam logic [11:0] OFF_HANDLER_END   = 12'h0FC;
    localparam logic [11:0] OFF_CUR_VECTOR    = 12'h100;
    localparam logic [11:0] OFF_FAST_VECTOR   = 12'h104;
    localparam logic [11:0] OFF_CUR_STATUS    = 12'h108;
    localparam logic [11:0] OFF_PENDING       = 12'h10C;
    localparam logic [11:0] OFF_ENABLED       = 12'h110;
    localparam logic [11:0] OFF_CORE_LINES    = 12'h114;
    localparam logic [11:0] OFF_ENABLE_CMD    = 12'h120;
    localparam logic [11:0] OFF_DISABLE_CMD   = 12'h124;
    localparam logic [11:0] OFF_CLEAR_CMD     = 12'h128;
    localparam logic [11:0] OFF_SET_CMD       = 12'h12C;
    localparam logic [11:0] OFF_END_SERVICE   = 12'h130;
    localparam logic [11:0] OFF_SPURIOUS      = 12'h134;
    localparam logic [11:0] OFF_DEBUG_CTRL    = 12'h138;
    localparam logic [11:0] OFF_REDIR_ENABLE  = 12'h140;
    localparam logic [11:0] OFF_REDIR_DISABLE = 12'h144;
    localparam logic [11:0] OFF_REDIR_STATUS  = 12'h148;

    // Field positions.
    localparam int PRIO_LSB      = 0;
    localparam int PRIO_MSB      = 2;
    localparam int TRIG_LSB      = 5;
    localparam int TRIG_MSB      = 6;
    localparam int DBG_PROTECT   = 0;
    localparam int DBG_GMASK     = 1;
    localparam int CORE_FAST_BIT = 0;
    localparam int CORE_NORM_BIT = 1;

    // Sources wired to external pins; all others are internal peripherals.
    localparam logic [31:0] EXT_SOURCE_MASK = 32'hE000_0001;

    localparam int          NUM_SOURCES = 32;
    localparam int          STACK_DEPTH = 8;
    localparam logic [31:0] RESET_WORD  = 32'h0000_0000;

    // Complete register state of the controller.
    typedef struct packed {
        logic [31:0][2:0]  prio;
        logic [31:0][1:0]  trig;
        logic [31:0][31:0] vec;
        logic [31:0]       spu;
        logic [1:0]        dbg;
        logic [31:0]       enab;
        logic [31:0]       latch;
        logic [31:0]       ffsr;
        logic [31:0]       lvlPrev;
        logic [4:0]        curId;
        logic [2:0]        curPrio;
        logic              curValid;
        logic [7:0][4:0]   stkId;
        logic [7:0][2:0]   stkPrio;
        logic [3:0]        depth;
        logic [4:0]        memId;
        logic              memValid;
        logic              ack;
        logic [31:0]       rdat;
        logic              irqAct;
        logic              fiqAct;
    } vic_state_t;

endpackage : vic_pkg

// [bench/vic_register_map_asserts.sv]
/*
 * Port checker of the vectored interrupt register map.
 * Assumes it is bound to vic_register_map and sees only its ports.
 */
`timescale 1ns/1ns
module vic_register_map_asserts
    import vic_pkg::*;
(
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic        wbCyc,
    input wire logic        wbStb,
    input wire logic        wbWe,
    input wire logic [31:0] wbAdr,
    input wire logic [3:0]  wbSel,
    input wire logic [31:0] wbDatW,
    input wire logic [31:0] wbDatR,
    input wire logic        wbAck,
    input wire logic [31:0] sourceIn,
    input wire logic        normalRequestLineN,
    input wire logic        fastRequestLineN
);
    logic take;
    logic rdTake;

    // A standing request without ack is taken; reads inside the window are watched.
    assign take   = wbCyc && wbStb && !wbAck;
    assign rdTake = take && !wbWe && wbAdr[31:12] == 20'hFFFFF;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_ack_one_pulse: assert property (wbAck |=> !wbAck)
        else $error("ack held longer than one cycle");
    a_ack_follows_req: assert property (take |=> wbAck)
        else $error("request not acknowledged in the next cycle");
    a_no_ack_idle: assert property (!(wbCyc && wbStb) |=> !wbAck)
        else $error("ack without a request");
    a_reset_lines_idle: assert property ($rose(resetn) |-> normalRequestLineN && fastRequestLineN && !wbAck)
        else $error("outputs active right after reset");
    a_reserved_reads_zero: assert property (rdTake && wbAdr[11:0] inside {12'h118, 12'h11C, 12'h13C,
        12'h120, 12'h124, 12'h128, 12'h12C, 12'h130, 12'h140, 12'h144} |=> wbDatR == 32'h0)
        else $error("reserved or write-only offset read nonzero");
    a_status_id_only: assert property (rdTake && wbAdr[11:0] == OFF_CUR_STATUS |=> wbDatR[31:5] == 27'h0)
        else $error("status word has bits above the source number");
    a_mode_spare_zero: assert property (rdTake && wbAdr[11:0] < OFF_HANDLER_ADDR
        |=> wbDatR[31:7] == 25'h0 && wbDatR[4:3] == 2'h0)
        else $error("mode register spare bits nonzero");
    a_core_lines_view: assert property (rdTake && wbAdr[11:0] == OFF_CORE_LINES
        |=> wbDatR == {30'h0, !$past(normalRequestLineN), !$past(fastRequestLineN)})
        else $error("core line status differs from the lines");
endmodule : vic_register_map_asserts

bind vic_register_map vic_register_map_asserts i_chk (.mclk(mclk), .resetn(resetn),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .sourceIn(sourceIn),
    .normalRequestLineN(normalRequestLineN), .fastRequestLineN(fastRequestLineN));

// [bench/vic_source_model.sv]
/*
 * Behavioural model of the peripheral and external interrupt sources.
 * Assumes the bench asks for a source by raising its bit in srcReq.
 */
`timescale 1ns/1ns
module vic_source_model
    import vic_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic [31:0] srcReq,
    output logic      [31:0] sourceIn
);
    // External pins idle high and are pulled low to request, so they are inverted here.
    always_ff @(posedge mclk)
    begin
        sourceIn <= srcReq ^ EXT_SOURCE_MASK;
    end
endmodule : vic_source_model

// [bench/vic_register_map_tb.sv]
/*
 * Self-checking bench of the vectored interrupt register map.
 * Assumes the one-cycle Wishbone answer of the design and a 10 MHz clock.
 */
`timescale 1ns/1ns
module vic_register_map_tb
    import vic_pkg::*;
;
    localparam logic [31:0] SPU = 32'hDEAD_0000;
    localparam logic [11:0] RST [11] = '{OFF_SOURCE_MODE, OFF_HANDLER_ADDR, OFF_HANDLER_END,
        OFF_CUR_VECTOR, OFF_FAST_VECTOR, OFF_CUR_STATUS, OFF_ENABLED, OFF_CORE_LINES,
        OFF_SPURIOUS, OFF_DEBUG_CTRL, OFF_REDIR_STATUS};
    logic        mclk;
    logic        resetn;
    logic        wbCyc;
    logic        wbStb;
    logic        wbWe;
    logic [31:0] wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatW;
    logic [31:0] wbDatR;
    logic        wbAck;
    logic [31:0] sourceIn;
    logic [31:0] srcReq;
    logic        normalRequestLineN;
    logic        fastRequestLineN;
    logic [31:0] q;
    int          n_fail;
    int          num_checks;

    vic_register_map i_dut (.mclk(mclk), .resetn(resetn), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
        .wbAck(wbAck), .sourceIn(sourceIn), .normalRequestLineN(normalRequestLineN),
        .fastRequestLineN(fastRequestLineN));
    vic_source_model i_src (.mclk(mclk), .srcReq(srcReq), .sourceIn(sourceIn));

    // Free-running 100 ns clock.
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Counts and ends the run; the only place a verdict is printed.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    // One classic transfer; the request stands until ack is sampled high.
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= w;
        wbAdr  <= a;
        wbDatW <= d;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (wbAck !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            n_fail++;
            $display("[FAIL] %0t no ack", $time);
        end
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge mclk);
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, {VIC_BASE_ADDR[31:12], a}, d);
    endtask : wr

    // Reads a word, inside the window unless told otherwise, and compares it.
    task automatic chk(input logic [11:0] a, input logic [31:0] e, input logic out = 1'b0);
        bus(1'b0, {out ? 20'h0 : VIC_BASE_ADDR[31:12], a}, 32'h0);
        num_checks++;
        if (q !== e)
        begin
            n_fail++;
            $display("[FAIL] %0t read %h got %h want %h", $time, a, q, e);
        end
    endtask : chk

    // Waits a bounded time for a request line to reach the wanted level.
    task automatic line(input logic fast, input logic lvl);
        int n;
        n = 0;
        while ((fast ? fastRequestLineN : normalRequestLineN) !== lvl && n < 10)
        begin
            @(posedge mclk);
            n++;
        end
        num_checks++;
        if (n >= 10)
        begin
            n_fail++;
            $display("[FAIL] %0t request line stuck", $time);
        end
    endtask : line

    // Hang guard, several times the expected run length.
    initial
    begin
        #(5000 * 100);
        n_fail++;
        give_verdict();
    end

    initial
    begin
        resetn = 1'b0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 32'h0;
        wbSel = 4'hF;
        wbDatW = 32'h0;
        srcReq = 32'h2000_0000;
        n_fail = 0;
        num_checks = 0;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        foreach (RST[i])
            chk(RST[i], 32'h0);
        chk(OFF_PENDING, 32'h2000_0000);
        srcReq <= 32'h0;
        $display("test reset done");
        wr(12'h004, 32'hFFFF_FFFF);
        chk(12'h004, 32'h0000_0067);
        wr(OFF_HANDLER_END, 32'hA5A5_5A5A);
        chk(OFF_HANDLER_END, 32'hA5A5_5A5A);
        chk(OFF_HANDLER_END, 32'h0, 1'b1);
        wr(OFF_DEBUG_CTRL, 32'hFFFF_FFFF);
        chk(OFF_DEBUG_CTRL, 32'h0000_0003);
        wr(OFF_DEBUG_CTRL, 32'h0);
        wr(OFF_CUR_STATUS, 32'hFFFF_FFFF);
        chk(OFF_CUR_STATUS, 32'h0);
        wr(12'h13C, 32'hFFFF_FFFF);
        chk(12'h13C, 32'h0);
        chk(OFF_SET_CMD, 32'h0);
        $display("test access done");
        wr(OFF_SPURIOUS, SPU);
        chk(OFF_SPURIOUS, SPU);
        chk(OFF_CUR_VECTOR, SPU);
        wr(12'h014, 32'h3);
        wr(12'h018, 32'h5);
        wr(12'h094, 32'h1000_0500);
        wr(12'h098, 32'h1000_0600);
        wr(OFF_ENABLE_CMD, 32'h60);
        srcReq <= 32'h60;
        line(1'b0, 1'b0);
        chk(OFF_CORE_LINES, 32'h2);
        chk(OFF_PENDING, 32'h60);
        chk(OFF_CUR_VECTOR, 32'h1000_0600);
        chk(OFF_CUR_STATUS, 32'h6);
        srcReq <= 32'h0;
        wr(OFF_END_SERVICE, 32'h0);
        chk(OFF_CUR_STATUS, 32'h0);
        chk(OFF_CUR_VECTOR, SPU);
        line(1'b0, 1'b1);
        $display("test vectoring done");
        wr(OFF_HANDLER_ADDR, 32'h0F00_0000);
        chk(OFF_FAST_VECTOR, SPU);
        wr(OFF_SET_CMD, 32'h1);
        wr(OFF_ENABLE_CMD, 32'h1);
        line(1'b1, 1'b0);
        chk(OFF_CORE_LINES, 32'h1);
        chk(OFF_FAST_VECTOR, 32'h0F00_0000);
        wr(OFF_CLEAR_CMD, 32'h1);
        chk(OFF_PENDING, 32'h0);
        line(1'b1, 1'b1);
        chk(OFF_ENABLED, 32'h61);
        wr(OFF_DISABLE_CMD, 32'h61);
        chk(OFF_ENABLED, 32'h0);
        wr(OFF_REDIR_ENABLE, 32'h20);
        chk(OFF_REDIR_STATUS, 32'h20);
        wr(OFF_REDIR_DISABLE, 32'h20);
        chk(OFF_REDIR_STATUS, 32'h0);
        $display("test fast done");
        // Level types on external source 30 and internal source 7 at both pin levels.
        for (int t = 0; t < 4; t += 2)
            for (int p = 0; p < 2; p++)
            begin
                wr(12'h078, 32'(t) << 5);
                wr(12'h01C, 32'(t) << 5);
                srcReq <= {1'b0, ~p[0], 22'h0, p[0], 7'h0};
                repeat (3) @(posedge mclk);
                chk(OFF_PENDING, {1'b0, (t == 2) == p, 22'h0, p[0], 7'h0});
            end
        srcReq <= 32'h0;
        wr(12'h078, 32'h20);
        wr(12'h01C, 32'h60);
        srcReq <= 32'h4000_0080;
        repeat (3) @(posedge mclk);
        srcReq <= 32'h0;
        repeat (3) @(posedge mclk);
        chk(OFF_PENDING, 32'h4000_0080);
        wr(OFF_CLEAR_CMD, 32'h4000_0080);
        chk(OFF_PENDING, 32'h0);
        $display("test trigger done");
        // Protect mode: the read only remembers, and the write to the vector acknowledges.
        wr(12'h09C, 32'h1000_0700);
        wr(OFF_ENABLE_CMD, 32'h80);
        wr(OFF_SET_CMD, 32'h80);
        wr(OFF_DEBUG_CTRL, 32'h1);
        chk(OFF_CUR_VECTOR, 32'h1000_0700);
        chk(OFF_CUR_STATUS, 32'h0);
        wr(OFF_CUR_VECTOR, 32'h0);
        chk(OFF_CUR_STATUS, 32'h7);
        chk(OFF_PENDING, 32'h0);
        wr(OFF_END_SERVICE, 32'h0);
        // The general mask holds the lines inactive although a source is pending.
        wr(OFF_DEBUG_CTRL, 32'h2);
        wr(OFF_SET_CMD, 32'h80);
        repeat (3) @(posedge mclk);
        chk(OFF_CORE_LINES, 32'h0);
        wr(OFF_DEBUG_CTRL, 32'h0);
        line(1'b0, 1'b0);
        chk(OFF_CORE_LINES, 32'h2);
        wr(OFF_CLEAR_CMD, 32'h80);
        $display("test protect done");
        give_verdict();
    end
endmodule : vic_register_map_tb
